/* rtl/ars_status_regs.sv */
// Alarm, readiness and service request status logic of the test instrument.
// Assumes a command decoder delivers one-cycle command strobes with arguments.
// How it works
// - Alarm query returns alarm register value
// - Only mask-enabled alarm bits raise change
// - Masked alarm set sets change flag bit9
// - Change flag and mask bit raise service
// - Pattern sync loss sets alarm bit six
// - Mask set takes number or bit name
// - Service mask OFF disables every reason
// - Bit1 follows gating start and stop
// - Bit3 set while answering, reads always set
// - Bit4 clears on setup start, sets done
// - Bit5 clears on test request, sets done
// - Bit6 autorange in external clock, read clears
// - Readiness read only via its query
// - Bits 0,2 reserved; bit7 reads zero
// - Alarm register tracks sixteen live indicators
`default_nettype none
`include "ars_params.svh"

module ars_status_regs #(
    parameter int AW = `ARS_ALARM_W,
    parameter int SW = `ARS_STA_W,
    parameter int unsigned AUTORANGE_CYC = `ARS_AUTORANGE_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Live alarm conditions
    input wire logic [AW-1:0] alarm_live_i,
    input wire logic sync_loss_i,
    // Other status register A conditions
    input wire logic [SW-1:0] sta_events_i,
    // Command strobe and argument
    input wire logic cmd_valid_i,
    input wire ars_pkg::ars_cmd_e cmd_i,
    input wire ars_pkg::ars_arg_e cmd_arg_kind_i,
    input wire logic [SW-1:0] cmd_arg_i,
    input wire logic serial_poll_i,
    // Instrument activity
    input wire logic result_query_busy_i,
    input wire logic auto_setup_start_i,
    input wire logic auto_setup_done_i,
    input wire logic self_test_req_i,
    input wire logic self_test_done_i,
    input wire logic external_tx_clock_mode_i,
    // Query reply
    output logic reply_valid_o,
    output logic [SW-1:0] reply_data_o,
    // Status views
    output logic [AW-1:0] alarm_o,
    output logic [7:0] instrument_readiness_o,
    output logic alarm_change_flag_o,
    output logic service_request_o
);
    typedef struct packed {
        logic [AW-1:0] alarm;
        logic [AW-1:0] amask;
        logic [SW-1:0] srq_mask;
        logic [SW-1:0] sta;
        logic [7:0] rdy;
        logic [31:0] ar_cnt;
        logic reply_valid;
        logic [SW-1:0] reply;
        logic srq;
    } ars_core_s;

    ars_core_s st_q;
    ars_core_s st_d;
    ars_change_if #(.W(AW)) chg ();

    logic [AW-1:0] alarm_now;
    logic take;
    logic rdy_read;
    logic sta_read;
    logic [SW-1:0] name_mask;

    always_comb begin
        alarm_now = alarm_live_i;
        alarm_now[`ARS_ALM_SYNC_LOSS] = alarm_live_i[`ARS_ALM_SYNC_LOSS] | sync_loss_i;
    end

    assign chg.alarm = alarm_now;
    assign chg.mask = st_q.amask;

    ars_change_det #(.W(AW)) u_det (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .chg(chg)
    );

    assign take = cmd_valid_i;
    assign rdy_read = take && (cmd_i == ars_pkg::ARS_CMD_READY_QUERY);
    assign sta_read = take && (cmd_i == ars_pkg::ARS_CMD_STATUS_A_QUERY);
    // Named argument selects one alarm bit by position
    assign name_mask = SW'(1) << cmd_arg_i[3:0];

    always_comb begin
        st_d = st_q;
        st_d.alarm = alarm_now;
        st_d.reply_valid = 1'b0;

        // --------------------------------------------------------------
        // Status register A
        // --------------------------------------------------------------
        // read or poll clears
        if (sta_read || serial_poll_i) begin
            st_d.sta = '0;
        end
        st_d.sta = st_d.sta | sta_events_i;
        if (chg.rise) begin
            st_d.sta[`ARS_STA_ALC_BIT] = 1'b1;
        end

        // --------------------------------------------------------------
        // Readiness register
        // --------------------------------------------------------------
        // read clears autorange
        if (rdy_read) begin
            st_d.rdy[`ARS_RDY_AUTORANGE] = 1'b0;
        end
        if (external_tx_clock_mode_i) begin
            if (st_q.ar_cnt >= AUTORANGE_CYC - 1) begin
                st_d.ar_cnt = '0;
                st_d.rdy[`ARS_RDY_AUTORANGE] = 1'b1;
            end else begin
                st_d.ar_cnt = st_q.ar_cnt + 32'h1;
            end
        end else begin
            st_d.ar_cnt = '0;
        end
        if (auto_setup_start_i) begin
            st_d.rdy[`ARS_RDY_AUTO_SETUP] = 1'b0;
        end else if (auto_setup_done_i) begin
            st_d.rdy[`ARS_RDY_AUTO_SETUP] = 1'b1;
        end
        if (self_test_req_i) begin
            st_d.rdy[`ARS_RDY_SELF_TEST] = 1'b0;
        end else if (self_test_done_i) begin
            st_d.rdy[`ARS_RDY_SELF_TEST] = 1'b1;
        end
        st_d.rdy[`ARS_RDY_DATA_OUT] = 1'b1;
        if (result_query_busy_i) begin
            st_d.rdy[`ARS_RDY_DATA_OUT] = 1'b1;
        end
        st_d.rdy[0] = 1'b0;
        st_d.rdy[2] = 1'b0;
        st_d.rdy[7] = 1'b0;

        // --------------------------------------------------------------
        // Commands
        // --------------------------------------------------------------
        if (take) begin
            case (cmd_i)
                ars_pkg::ARS_CMD_ALARM_QUERY: begin
                    st_d.reply_valid = 1'b1;
                    st_d.reply = st_q.alarm;
                end
                ars_pkg::ARS_CMD_READY_QUERY: begin
                    st_d.reply_valid = 1'b1;
                    st_d.reply = {{(SW-8){1'b0}}, st_q.rdy};
                end
                ars_pkg::ARS_CMD_STATUS_A_QUERY: begin
                    st_d.reply_valid = 1'b1;
                    st_d.reply = st_q.sta;
                end
                ars_pkg::ARS_CMD_ALARM_MASK_SET: begin
                    if (cmd_arg_kind_i == ars_pkg::ARS_ARG_NAME) begin
                        st_d.amask = name_mask;
                    end else begin
                        st_d.amask = cmd_arg_i;
                    end
                end
                ars_pkg::ARS_CMD_SERVICE_MASK_SET: begin
                    case (cmd_arg_kind_i)
                        ars_pkg::ARS_ARG_ON: st_d.srq_mask = `ARS_SRQ_MASK_ON;
                        ars_pkg::ARS_ARG_OFF: st_d.srq_mask = `ARS_SRQ_MASK_OFF;
                        default: st_d.srq_mask = cmd_arg_i;
                    endcase
                end
                ars_pkg::ARS_CMD_GATING_START: st_d.rdy[`ARS_RDY_GATING] = 1'b1;
                ars_pkg::ARS_CMD_GATING_STOP: st_d.rdy[`ARS_RDY_GATING] = 1'b0;
                default: begin
                end
            endcase
        end

        st_d.srq = |(st_d.sta & st_d.srq_mask);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.alarm <= `ARS_ALM_RESET;
            st_q.amask <= `ARS_AMASK_RESET;
            st_q.srq_mask <= `ARS_SRQ_MASK_RESET;
            st_q.sta <= '0;
            st_q.rdy <= `ARS_RDY_RESET;
            st_q.ar_cnt <= '0;
            st_q.reply_valid <= 1'b0;
            st_q.reply <= '0;
            st_q.srq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reply_valid_o = st_q.reply_valid;
    assign reply_data_o = st_q.reply;
    assign alarm_o = st_q.alarm;
    assign instrument_readiness_o = st_q.rdy;
    assign alarm_change_flag_o = st_q.sta[`ARS_STA_ALC_BIT];
    assign service_request_o = st_q.srq;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    a_alarm_query_reply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_ALARM_QUERY
        |=> reply_valid_o && reply_data_o == $past(alarm_o))
        else $error("alarm query reply wrong");
    a_change_sets_flag: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        chg.rise |=> alarm_change_flag_o)
        else $error("change flag not set");
    a_srq_follows: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_change_flag_o && st_q.srq_mask[`ARS_STA_ALC_BIT] && !serial_poll_i && !sta_read
        && !(take && cmd_i == ars_pkg::ARS_CMD_SERVICE_MASK_SET)
        |=> service_request_o)
        else $error("service request missing");
    a_sync_loss_bit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        sync_loss_i |=> alarm_o[`ARS_ALM_SYNC_LOSS])
        else $error("sync loss bit not set");
    a_name_mask_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_ALARM_MASK_SET
        && cmd_arg_kind_i == ars_pkg::ARS_ARG_NAME |=> chg.mask == $past(name_mask))
        else $error("named alarm mask not loaded");
    a_mask_off_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_SERVICE_MASK_SET
        && cmd_arg_kind_i == ars_pkg::ARS_ARG_OFF |=> !service_request_o)
        else $error("request after mask off");
    a_gating_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_GATING_START
        |=> instrument_readiness_o[`ARS_RDY_GATING])
        else $error("gating bit not set");
    a_gating_bit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_GATING_STOP
        |=> !instrument_readiness_o[`ARS_RDY_GATING])
        else $error("gating bit not cleared");
    a_data_out_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        instrument_readiness_o[`ARS_RDY_DATA_OUT])
        else $error("data ready bit clear");
    a_setup_start_clr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        auto_setup_start_i |=> !instrument_readiness_o[`ARS_RDY_AUTO_SETUP])
        else $error("setup bit not cleared");
    a_self_test_clr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        self_test_req_i |=> !instrument_readiness_o[`ARS_RDY_SELF_TEST])
        else $error("self test bit not cleared");
    a_self_test_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        self_test_done_i && !self_test_req_i
        |=> instrument_readiness_o[`ARS_RDY_SELF_TEST])
        else $error("self test bit not set");
    a_autorange_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        external_tx_clock_mode_i && st_q.ar_cnt >= AUTORANGE_CYC - 1
        |=> instrument_readiness_o[`ARS_RDY_AUTORANGE])
        else $error("autorange bit not set");
    a_autorange_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        rdy_read && !(external_tx_clock_mode_i && st_q.ar_cnt >= AUTORANGE_CYC - 1)
        |=> !instrument_readiness_o[`ARS_RDY_AUTORANGE])
        else $error("autorange bit not cleared by read");
    a_ready_reply: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        take && cmd_i == ars_pkg::ARS_CMD_READY_QUERY
        |=> reply_valid_o && reply_data_o[7:0] == $past(instrument_readiness_o))
        else $error("readiness reply wrong");
    a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !instrument_readiness_o[7] && !instrument_readiness_o[0])
        else $error("reserved readiness bit set");
    a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        alarm_change_flag_o && !serial_poll_i && !sta_read
        |=> alarm_change_flag_o)
        else $error("change flag lost");
    a_srq_drops: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        serial_poll_i && !chg.rise && sta_events_i == '0 && !take
        |=> !service_request_o)
        else $error("request stuck after poll");
endmodule : ars_status_regs

`default_nettype wire

/* rtl/ars_params.svh */
// Constants for the alarm and readiness status block.
// Assumes a 100 MHz instrument clock; included by the design files.
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH

// --------------------------------------------------------------------------
// Alarm register layout
// --------------------------------------------------------------------------
`define ARS_ALARM_W 16
`define ARS_ALM_BIT_ERROR 4
`define ARS_ALM_SYNC_LOSS 6
`define ARS_ALM_RESET 16'h0000
`define ARS_AMASK_RESET 16'h0000

// --------------------------------------------------------------------------
// Status register A and service request mask
// --------------------------------------------------------------------------
`define ARS_STA_W 16
`define ARS_STA_ALC_BIT 9
`define ARS_SRQ_MASK_RESET 16'h0020
`define ARS_SRQ_MASK_ON 16'hFFFF
`define ARS_SRQ_MASK_OFF 16'h0000

// --------------------------------------------------------------------------
// Readiness register layout
// --------------------------------------------------------------------------
`define ARS_RDY_GATING 1
`define ARS_RDY_DATA_OUT 3
`define ARS_RDY_AUTO_SETUP 4
`define ARS_RDY_SELF_TEST 5
`define ARS_RDY_AUTORANGE 6
`define ARS_RDY_RESET 8'h38

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define ARS_CLK_MHZ 100
`define ARS_AUTORANGE_MS 3000
`define ARS_AUTORANGE_CYC (`ARS_AUTORANGE_MS * 1000 * `ARS_CLK_MHZ)

`endif

/* rtl/ars_pkg.sv */
// Types shared by the alarm and readiness status block.
// Assumes nothing of its surroundings.
`default_nettype none

package ars_pkg;
    // Query or set command selected by the decoder
    typedef enum logic [2:0] {
        ARS_CMD_NONE,
        ARS_CMD_ALARM_QUERY,
        ARS_CMD_READY_QUERY,
        ARS_CMD_STATUS_A_QUERY,
        ARS_CMD_ALARM_MASK_SET,
        ARS_CMD_SERVICE_MASK_SET,
        ARS_CMD_GATING_START,
        ARS_CMD_GATING_STOP
    } ars_cmd_e;

    // Argument form of a mask set command
    typedef enum logic [1:0] {
        ARS_ARG_NUMBER,
        ARS_ARG_NAME,
        ARS_ARG_ON,
        ARS_ARG_OFF
    } ars_arg_e;
endpackage : ars_pkg

`default_nettype wire

/* rtl/ars_change_if.sv */
// Carrier between the status core and the alarm change detector.
// Assumes one clock shared by both ends.
`default_nettype none

interface ars_change_if #(parameter int W = 16);
    logic [W-1:0] alarm;
    logic [W-1:0] mask;
    logic rise;
    modport core (output alarm, output mask, input rise);
    modport det (input alarm, input mask, output rise);
endinterface : ars_change_if

`default_nettype wire

/* rtl/ars_change_det.sv */
// Masked rising-edge detector on the live alarm word.
// Assumes alarm bits are synchronous to the clock.
`default_nettype none
`include "ars_params.svh"

module ars_change_det #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Alarm word and mask
    ars_change_if.det chg
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic rise;
    } ars_det_s;

    ars_det_s st_q;
    ars_det_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.prev = chg.alarm;
        st_d.rise = |(chg.alarm & ~st_q.prev & chg.mask);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign chg.rise = st_q.rise;

    a_unmasked_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ((chg.alarm & ~st_q.prev & chg.mask) == '0) |=> !chg.rise)
        else $error("rise without masked alarm edge");
endmodule : ars_change_det

`default_nettype wire

/* dv/ars_host_model.sv */
// Bus controller model: command strobes, serial polls and ready polling.
// Assumes the device takes a strobe at a rising edge and replies one cycle later.
`default_nettype none

module ars_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Command side
    output logic cmd_valid_o,
    output ars_pkg::ars_cmd_e cmd_o,
    output ars_pkg::ars_arg_e arg_kind_o,
    output logic [15:0] arg_o,
    output logic serial_poll_o,
    // Reply side
    input wire logic reply_valid_i,
    input wire logic [15:0] reply_data_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = ars_pkg::ARS_CMD_NONE;
        arg_kind_o = ars_pkg::ARS_ARG_NUMBER;
        arg_o = 16'h0000;
        serial_poll_o = 1'b0;
    end

    // One strobe; the argument lines then show the inverse, not a stale value
    task automatic send(input ars_pkg::ars_cmd_e c, input ars_pkg::ars_arg_e k,
                        input logic [15:0] a, output logic ok, output logic [15:0] d);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_o = c;
        arg_kind_o = k;
        arg_o = a;
        @(negedge ref_clk_i);
        // Reply stands for one cycle only, so it is taken before the strobe drops
        ok = reply_valid_i;
        d = reply_data_i;
        cmd_valid_o = 1'b0;
        cmd_o = ars_pkg::ARS_CMD_NONE;
        arg_o = ~a;
    endtask : send

    task automatic poll();
        @(negedge ref_clk_i);
        serial_poll_o = 1'b1;
        @(negedge ref_clk_i);
        serial_poll_o = 1'b0;
        @(negedge ref_clk_i);
    endtask : poll

    task automatic wait_setup(output logic done);
        logic ok;
        logic [15:0] d;
        done = 1'b0;
        for (int i = 0; i < 40 && !done; i++) begin
            send(ars_pkg::ARS_CMD_READY_QUERY, ars_pkg::ARS_ARG_NUMBER, 16'h0000, ok, d);
            done = ok && d[4];
            repeat (4) @(negedge ref_clk_i);
        end
    endtask : wait_setup
endmodule : ars_host_model

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench of the alarm and readiness status block.
// Assumes the host model issues commands while the bench drives live conditions.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned AR_CYC = 20;
    logic ref_clk_i, sys_rst_i, sync_loss, busy, ext_mode, cmd_valid, spoll, rvalid, ok;
    logic flag, srq;
    logic [3:0] act;
    logic [15:0] live, sta_ev, arg, rdata, alarm, d;
    logic [7:0] ready;
    logic [31:0] seed;
    logic [5:0] tbl [7];
    ars_pkg::ars_cmd_e cmd;
    ars_pkg::ars_arg_e kind;
    int bad_count, total_checks, cycles;

    ars_status_regs #(.AUTORANGE_CYC(AR_CYC)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .alarm_live_i(live), .sync_loss_i(sync_loss), .sta_events_i(sta_ev),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_arg_kind_i(kind), .cmd_arg_i(arg),
        .serial_poll_i(spoll), .result_query_busy_i(busy),
        .auto_setup_start_i(act[3]), .auto_setup_done_i(act[2]),
        .self_test_req_i(act[1]), .self_test_done_i(act[0]),
        .external_tx_clock_mode_i(ext_mode),
        .reply_valid_o(rvalid), .reply_data_o(rdata), .alarm_o(alarm),
        .instrument_readiness_o(ready), .alarm_change_flag_o(flag), .service_request_o(srq)
    );

    ars_host_model host (
        .ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .arg_kind_o(kind),
        .arg_o(arg), .serial_poll_o(spoll), .reply_valid_i(rvalid), .reply_data_i(rdata)
    );

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [15:0] ready_exp(input logic g, input logic a, input logic s,
                                              input logic r);
        return {8'h00, 1'b0, r, s, a, 1'b1, 1'b0, g, 1'b0};
    endfunction : ready_exp

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic fs(input logic f, input logic s);
        chk("change flag", {15'h0000, f}, {15'h0000, flag});
        chk("service request", {15'h0000, s}, {15'h0000, srq});
    endtask : fs

    // Alarm change lands one edge after the alarm register takes it
    task automatic drive(input logic [15:0] v, input logic s);
        @(negedge ref_clk_i);
        live = v;
        sync_loss = s;
        repeat (3) @(negedge ref_clk_i);
    endtask : drive

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // --------------------------------------------------------------------
    // Clock and timeout
    // --------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        live = 16'h0000;
        sync_loss = 1'b0;
        sta_ev = 16'h0000;
        busy = 1'b0;
        act = 4'h0;
        ext_mode = 1'b0;
        seed = 32'h0000C518;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        tbl = '{6'h21, 6'h13, 6'h31, 6'h08, 6'h05, 6'h0C, 6'h17};
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk("readiness", ready_exp(1'b0, 1'b1, 1'b1, 1'b0), {8'h00, ready});
        fs(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            @(negedge ref_clk_i);
            live = seed[15:0];
            sync_loss = seed[16];
            busy = seed[17];
            host.send(ars_pkg::ARS_CMD_ALARM_QUERY, ars_pkg::ARS_ARG_NUMBER, seed[31:16], ok, d);
            chk("alarm reply", live | {9'h000, sync_loss, 6'h00}, d);
            chk("alarm register", live | {9'h000, sync_loss, 6'h00}, alarm);
            chk("reply valid", 16'h0001, {15'h0000, ok});
            chk("data ready bit", 16'h0001, {15'h0000, ready[3]});
            chk("change flag", 16'h0000, {15'h0000, flag});
        end
        drive(16'h0000, 1'b0);
        host.poll();
        host.send(ars_pkg::ARS_CMD_ALARM_MASK_SET, ars_pkg::ARS_ARG_NUMBER, 16'h0040, ok, d);
        host.send(ars_pkg::ARS_CMD_SERVICE_MASK_SET, ars_pkg::ARS_ARG_NUMBER, 16'h0200, ok, d);
        drive(16'h0010, 1'b0);
        fs(1'b0, 1'b0);
        drive(16'h0010, 1'b1);
        fs(1'b1, 1'b1);
        host.poll();
        fs(1'b0, 1'b0);
        host.send(ars_pkg::ARS_CMD_ALARM_MASK_SET, ars_pkg::ARS_ARG_NAME, 16'h0004, ok, d);
        drive(16'h0000, 1'b1);
        drive(16'h0010, 1'b1);
        fs(1'b1, 1'b1);
        host.send(ars_pkg::ARS_CMD_STATUS_A_QUERY, ars_pkg::ARS_ARG_NUMBER, 16'h0000, ok, d);
        chk("status A reply", 16'h0200, d);
        fs(1'b0, 1'b0);
        host.send(ars_pkg::ARS_CMD_SERVICE_MASK_SET, ars_pkg::ARS_ARG_OFF, 16'hFFFF, ok, d);
        drive(16'h0000, 1'b1);
        drive(16'h0010, 1'b1);
        fs(1'b1, 1'b0);
        host.send(ars_pkg::ARS_CMD_SERVICE_MASK_SET, ars_pkg::ARS_ARG_ON, 16'h0000, ok, d);
        fs(1'b1, 1'b1);
        host.poll();
        fs(1'b0, 1'b0);
        @(negedge ref_clk_i);
        sta_ev = 16'h0020;
        @(negedge ref_clk_i);
        sta_ev = 16'h0000;
        fs(1'b0, 1'b1);
        host.poll();
        fs(1'b0, 1'b0);
        host.send(ars_pkg::ARS_CMD_GATING_START, ars_pkg::ARS_ARG_NUMBER, 16'h0000, ok, d);
        chk("readiness", ready_exp(1'b1, 1'b1, 1'b1, 1'b0), {8'h00, ready});
        host.send(ars_pkg::ARS_CMD_GATING_STOP, ars_pkg::ARS_ARG_NUMBER, 16'h0000, ok, d);
        chk("readiness", ready_exp(1'b0, 1'b1, 1'b1, 1'b0), {8'h00, ready});
        foreach (tbl[i]) begin
            @(negedge ref_clk_i);
            act = tbl[i][5:2];
            @(negedge ref_clk_i);
            act = 4'h0;
            chk("readiness", ready_exp(1'b0, tbl[i][1], tbl[i][0], 1'b0), {8'h00, ready});
        end
        @(negedge ref_clk_i);
        act = 4'h8;
        @(negedge ref_clk_i);
        act = 4'h0;
        fork
            begin
                repeat (12) @(negedge ref_clk_i);
                act = 4'h4;
                @(negedge ref_clk_i);
                act = 4'h0;
            end
            host.wait_setup(ok);
        join
        chk("setup seen", 16'h0001, {15'h0000, ok});
        @(negedge ref_clk_i);
        ext_mode = 1'b1;
        repeat (AR_CYC + 5) @(negedge ref_clk_i);
        ext_mode = 1'b0;
        chk("readiness", ready_exp(1'b0, 1'b1, 1'b1, 1'b1), {8'h00, ready});
        host.send(ars_pkg::ARS_CMD_READY_QUERY, ars_pkg::ARS_ARG_NUMBER, 16'h0000, ok, d);
        chk("ready reply", ready_exp(1'b0, 1'b1, 1'b1, 1'b1), d);
        chk("readiness", ready_exp(1'b0, 1'b1, 1'b1, 1'b0), {8'h00, ready});
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
